//--- rtl/fps_regs.sv
// Purpose: data flash protect and flash status registers behind APB
// Assumes: engine inputs come from logic on clk; one clock, async high reset
// Notes: a control word holds command enable and the two interrupt enables
// Notes: read data is latched in the setup cycle and stands through the access
`include "fps_cfg.svh"
`timescale 1ns/1ps

module fps_regs
(
    input wire logic clk,                   // 200 MHz system clock
    input wire logic rst,                   // async reset, active high
    input wire logic psel,                  // apb select
    input wire logic penable,               // apb access phase
    input wire logic pwrite,                // apb direction
    input wire logic [31:0] paddr,          // apb byte address
    input wire logic [31:0] pwdata,         // apb write data
    output logic [31:0] prdata,             // apb read data, registered
    output logic pready,                    // apb ready, always high
    output logic pslverr,                   // apb error on unmapped address
    input wire fps_pkg::fps_eng_t eng,      // engine events
    input wire fps_pkg::fps_cmd_t cmd_in,   // software command request
    output logic cmd_accept,                // command allowed to proceed
    output logic cmd_refuse,                // command refused by protection
    output logic sw_command_enable,         // command enable level
    output logic flash_irq                  // flash interrupt request level
);
    import fps_pkg::*;

    // ==========================================================
    // state
    logic area_a_protect, area_b_protect;
    logic ready_irq_flag, busy_read_irq_flag;
    logic erase_blank_error, program_error;
    logic ready_irq_enable, busy_read_irq_enable;
    logic ready_q, rirq_seen, birq_seen;
    logic next_area_a_protect, next_area_b_protect;
    logic next_ready_irq_flag, next_busy_read_irq_flag;
    logic next_erase_blank_error, next_program_error;
    logic next_sw_command_enable, next_ready_irq_enable, next_busy_read_irq_enable;
    logic next_rirq_seen, next_birq_seen;
    logic [31:0] next_prdata;
    logic wr, rd, hit_pr, hit_st, hit_ct, cmden_rise;
    logic [7:0] status_word;
    logic rd_setup; // setup cycle of a read

    // ==========================================================
    // bus decode; zero wait states keep the master simple
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign hit_pr = (paddr == `FPS_ADDR_PROTECT);
    assign hit_st = (paddr == `FPS_ADDR_STATUS);
    assign hit_ct = (paddr == `FPS_ADDR_CTRL);
    assign pslverr = psel & penable & ~(hit_pr | hit_st | hit_ct);

    // status image as software sees it
    always_comb
    begin
        status_word = 8'h00;
        status_word[`FPS_ST_RDY] = eng.ready;
        status_word[`FPS_ST_RSV1] = eng.ready;
        status_word[`FPS_ST_RSV2] = 1'b0;
        status_word[`FPS_ST_PERR] = program_error;
        status_word[`FPS_ST_SUSP] = eng.suspend;
        status_word[`FPS_ST_EERR] = erase_blank_error;
        status_word[`FPS_ST_BIRQ] = busy_read_irq_flag;
        status_word[`FPS_ST_RIRQ] = ready_irq_flag;
    end

    // ==========================================================
    // protection gate on commands
    // a refused command is simply not passed on; nothing about it is latched
    assign cmd_refuse = cmd_in.valid & (cmd_in.area_b ? area_b_protect : area_a_protect);
    assign cmd_accept = cmd_in.valid & ~cmd_refuse;
    assign flash_irq = (ready_irq_flag & ready_irq_enable)
                     | (busy_read_irq_flag & busy_read_irq_enable);

    // ==========================================================
    // control group; a command enable rise also drops both interrupt enables
    assign cmden_rise = wr & hit_ct & pwdata[`FPS_CT_CMDEN] & ~sw_command_enable;
    always_comb
    begin
        next_sw_command_enable = sw_command_enable;
        next_ready_irq_enable = ready_irq_enable;
        next_busy_read_irq_enable = busy_read_irq_enable;
        if (wr && hit_ct)
        begin
            next_sw_command_enable = pwdata[`FPS_CT_CMDEN];
            next_ready_irq_enable = pwdata[`FPS_CT_RIE];
            next_busy_read_irq_enable = pwdata[`FPS_CT_BIE];
        end
        // software must set the enables again after each rise
        if (cmden_rise)
        begin
            next_ready_irq_enable = 1'b0;
            next_busy_read_irq_enable = 1'b0;
        end
    end

    // control registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sw_command_enable <= 1'b0;
            ready_irq_enable <= 1'b0;
            busy_read_irq_enable <= 1'b0;
        end
        else
        begin
            sw_command_enable <= next_sw_command_enable;
            ready_irq_enable <= next_ready_irq_enable;
            busy_read_irq_enable <= next_busy_read_irq_enable;
        end
    end

    // ==========================================================
    // protect group; bits 7 to 2 are not stored, so they always read zero
    always_comb
    begin
        next_area_a_protect = area_a_protect;
        next_area_b_protect = area_b_protect;
        if (wr && hit_pr)
        begin
            next_area_a_protect = pwdata[`FPS_PR_A];
            next_area_b_protect = pwdata[`FPS_PR_B];
        end
        // forced set wins, so a write cannot leave an area open across a rise
        if (cmden_rise)
        begin
            next_area_a_protect = 1'b1;
            next_area_b_protect = 1'b1;
        end
    end

    // protect registers; both areas open after reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            area_a_protect <= 1'b0;
            area_b_protect <= 1'b0;
        end
        else
        begin
            area_a_protect <= next_area_a_protect;
            area_b_protect <= next_area_b_protect;
        end
    end

    // ==========================================================
    // interrupt flag group; the arm copies the bit exactly as software read it,
    // so a flag set between setup and access cannot be cleared unseen
    always_comb
    begin
        next_ready_irq_flag = ready_irq_flag;
        next_busy_read_irq_flag = busy_read_irq_flag;
        next_rirq_seen = rirq_seen;
        next_birq_seen = birq_seen;
        if (rd && hit_st)
        begin
            next_rirq_seen = prdata[`FPS_ST_RIRQ];
            next_birq_seen = prdata[`FPS_ST_BIRQ];
        end
        // any status write uses up both arms; ones written are ignored
        if (wr && hit_st)
        begin
            if (!pwdata[`FPS_ST_RIRQ] && rirq_seen)
            begin
                next_ready_irq_flag = 1'b0;
            end
            if (!pwdata[`FPS_ST_BIRQ] && birq_seen)
            begin
                next_busy_read_irq_flag = 1'b0;
            end
            next_rirq_seen = 1'b0;
            next_birq_seen = 1'b0;
        end
        // hardware sets come last so they win over a clear in the same cycle
        if (eng.ready && !ready_q)
        begin
            next_ready_irq_flag = 1'b1;
        end
        if (eng.rom_access && !eng.ready)
        begin
            next_busy_read_irq_flag = 1'b1;
        end
    end

    // flag registers; ready_q resets to ready so no false edge at release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ready_irq_flag <= 1'b0;
            busy_read_irq_flag <= 1'b0;
            rirq_seen <= 1'b0;
            birq_seen <= 1'b0;
            ready_q <= 1'b1;
        end
        else
        begin
            ready_irq_flag <= next_ready_irq_flag;
            busy_read_irq_flag <= next_busy_read_irq_flag;
            rirq_seen <= next_rirq_seen;
            birq_seen <= next_birq_seen;
            ready_q <= eng.ready;
        end
    end

    // ==========================================================
    // error group; clear-status first, so a failure in the same cycle stays
    always_comb
    begin
        next_erase_blank_error = erase_blank_error;
        next_program_error = program_error;
        if (eng.clear_stat)
        begin
            next_erase_blank_error = 1'b0;
            next_program_error = 1'b0;
        end
        if (eng.erase_fail)
        begin
            next_erase_blank_error = 1'b1;
        end
        if (eng.prog_fail)
        begin
            next_program_error = 1'b1;
        end
    end

    // error registers; no error is pending after reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            erase_blank_error <= 1'b0;
            program_error <= 1'b0;
        end
        else
        begin
            erase_blank_error <= next_erase_blank_error;
            program_error <= next_program_error;
        end
    end

    // ==========================================================
    // read data group; latched at the end of the setup cycle so that it
    // stands through the whole access cycle, when the master takes it;
    // the cost is one register stage, bought back by zero wait states
    always_comb
    begin
        next_prdata = `FPS_ZERO32;
        if (rd_setup)
        begin
            if (hit_pr)
            begin
                next_prdata[`FPS_PR_A] = area_a_protect;
                next_prdata[`FPS_PR_B] = area_b_protect;
            end
            else if (hit_st)
            begin
                next_prdata[`FPS_ST_RIRQ:`FPS_ST_RDY] = status_word;
            end
            else if (hit_ct)
            begin
                next_prdata[`FPS_CT_CMDEN] = sw_command_enable;
                next_prdata[`FPS_CT_RIE] = ready_irq_enable;
                next_prdata[`FPS_CT_BIE] = busy_read_irq_enable;
            end
        end
    end

    // read data register; zero outside a read so stale data never leaks
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= `FPS_ZERO32;
        end
        else
        begin
            prdata <= next_prdata;
        end
    end
endmodule

//--- rtl/fps_cfg.svh
// Purpose: offsets, field positions and reset values of the flash protect/status block
// Assumes: 32-bit APB, each register on its own aligned word
// Notes: printed offsets are odd, so each is kept as an index, byte address = 4 * index
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

// register indices and their byte addresses
`define FPS_IDX_PROTECT 24'hff0662
`define FPS_IDX_STATUS 24'hff0663
`define FPS_IDX_CTRL 24'hff0664
`define FPS_ADDR_PROTECT 32'h03fc1988
`define FPS_ADDR_STATUS 32'h03fc198c
`define FPS_ADDR_CTRL 32'h03fc1990

// protect register fields
`define FPS_PR_A 0
`define FPS_PR_B 1
`define FPS_PR_RESET 2'h0

// status register fields
`define FPS_ST_RDY 0
`define FPS_ST_RSV1 1
`define FPS_ST_RSV2 2
`define FPS_ST_PERR 3
`define FPS_ST_SUSP 4
`define FPS_ST_EERR 5
`define FPS_ST_BIRQ 6
`define FPS_ST_RIRQ 7

// control register fields
`define FPS_CT_CMDEN 0
`define FPS_CT_RIE 1
`define FPS_CT_BIE 2
`define FPS_CT_RESET 3'h0

`define FPS_ZERO32 32'h00000000
`endif

//--- rtl/fps_pkg.sv
// Purpose: types shared by the flash protect/status block
// Assumes: nothing beyond the cfg header
// Notes: flash engine events travel as one packed struct
package fps_pkg;
    // events reported by the program/erase engine
    typedef struct packed {
        logic ready;       // flash ready level (1 ready, 0 busy)
        logic suspend;     // erase-suspend in use
        logic prog_fail;   // program or lock-bit program failed, pulse
        logic erase_fail;  // erase failed or blank check not blank, pulse
        logic clear_stat;  // clear-status command issued, pulse
        logic rom_access;  // user rom area accessed, pulse
    } fps_eng_t;

    // command request toward a data flash area
    typedef struct packed {
        logic valid;       // command present
        logic area_b;      // 1 area b, 0 area a
    } fps_cmd_t;
endpackage

//--- dv/fps_regs_sva.sv
// Purpose: port-level checks of the flash protect/status block
// Assumes: one clock, async high reset, read data stands in the access cycle
// Notes: ready and suspend checks wait until engine levels have been quiet
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_regs_sva
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pslverr, // apb error
    input wire fps_pkg::fps_eng_t eng, // engine events
    input wire fps_pkg::fps_cmd_t cmd_in, // command request
    input wire logic cmd_accept, // command allowed
    input wire logic cmd_refuse, // command refused
    input wire logic sw_command_enable, // enable level
    input wire logic flash_irq // interrupt level
);
    import fps_pkg::*;
    logic acc;
    logic rd_st;
    logic [1:0] prev;
    logic [1:0] next_prev;
    logic [1:0] quiet;
    logic [1:0] next_quiet;
    // =========================================
    // quiet counter, status bits may lag the engine by a register
    assign acc = psel && penable;
    assign rd_st = acc && !pwrite && paddr == `FPS_ADDR_STATUS;
    always_comb
    begin
        next_prev = {eng.ready, eng.suspend};
        next_quiet = (next_prev != prev) ? 2'h0 : ((quiet == 2'h3) ? 2'h3 : quiet + 2'h1);
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev <= 2'h2;
            quiet <= 2'h0;
        end
        else
        begin
            prev <= next_prev;
            quiet <= next_quiet;
        end
    end
    // =========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_cmd_onehot: assert property (cmd_in.valid |-> cmd_accept ^ cmd_refuse)
        else $error("command not answered exactly once");
    chk_cmd_idle: assert property (!cmd_in.valid |-> !cmd_accept && !cmd_refuse)
        else $error("command answer without request");
    chk_bad_addr: assert property (acc && paddr != `FPS_ADDR_PROTECT
        && paddr != `FPS_ADDR_STATUS && paddr != `FPS_ADDR_CTRL |-> pslverr)
        else $error("unmapped access without error");
    chk_prot_rsv: assert property (acc && !pwrite && paddr == `FPS_ADDR_PROTECT
        |-> prdata[31:2] == 30'h0) else $error("protect reserved bits not zero");
    chk_stat_rsv: assert property (rd_st |-> !prdata[2] && prdata[1] == prdata[0])
        else $error("status reserved bits wrong");
    chk_stat_rdy: assert property (rd_st && quiet == 2'h3 |-> prdata[0] == $past(eng.ready))
        else $error("ready bit differs from engine");
    chk_stat_susp: assert property (rd_st && quiet == 2'h3 |-> prdata[4] == $past(eng.suspend))
        else $error("suspend bit differs from engine");
    chk_en_protect: assert property ($rose(sw_command_enable) && cmd_in.valid |-> cmd_refuse)
        else $error("command accepted after enable rise");
    chk_en_irq_off: assert property ($rose(sw_command_enable) |-> !flash_irq)
        else $error("interrupt left on after enable rise");
    cover property (acc && pwrite && paddr == `FPS_ADDR_CTRL);
    cover property (cmd_refuse);
    cover property (flash_irq);
endmodule

bind fps_regs fps_regs_sva u_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .eng(eng),
    .cmd_in(cmd_in), .cmd_accept(cmd_accept), .cmd_refuse(cmd_refuse),
    .sw_command_enable(sw_command_enable), .flash_irq(flash_irq));

//--- dv/fps_regs_bench.sv
// Purpose: directed bench for the flash protect/status block
// Assumes: read data is taken at the access edge, where pready is high
// Notes: engine and command inputs are driven straight from here
`timescale 1ns/1ps
`include "fps_cfg.svh"
module fps_regs_bench;
    import fps_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmd_accept;
    logic cmd_refuse;
    logic sw_command_enable;
    logic flash_irq;
    fps_eng_t eng = 6'h20;
    fps_cmd_t cmd = 2'h0;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [31:0] ST = `FPS_ADDR_STATUS;
    localparam logic [31:0] PR = `FPS_ADDR_PROTECT;
    localparam logic [31:0] CT = `FPS_ADDR_CTRL;
    always #2.5 clk = ~clk;
    fps_regs u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eng(eng), .cmd_in(cmd), .cmd_accept(cmd_accept), .cmd_refuse(cmd_refuse),
        .sw_command_enable(sw_command_enable), .flash_irq(flash_irq));
    // =========================================
    // shared tasks
    task automatic conclude();
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; read data taken at the access edge, one idle edge after
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        eng[b] <= 1'b1;
        @(posedge clk);
        eng[b] <= 1'b0;
    endtask
    task automatic cmd_try(input logic b, input logic ok);
        @(posedge clk);
        cmd <= {1'b1, b};
        @(posedge clk);
        check({30'h0, cmd_accept, cmd_refuse}, {30'h0, ok, !ok}, "command answer");
        cmd <= 2'h0;
    endtask
    // =========================================
    // scenarios
    task automatic t_protect();
        apb(1'b0, ST, 32'h0);
        check(rd, 32'h3, "status after reset");
        cmd_try(1'b0, 1'b1);
        cmd_try(1'b1, 1'b1);
        @(posedge clk);
        cmd <= 2'h2;
        apb(1'b1, CT, 32'h7);
        cmd <= 2'h0;
        check({31'h0, sw_command_enable}, 32'h1, "command enable set");
        apb(1'b0, CT, 32'h0);
        check(rd, 32'h1, "enables dropped on rise");
        apb(1'b0, PR, 32'h0);
        check(rd, 32'h3, "forced protect");
        cmd_try(1'b0, 1'b0);
        cmd_try(1'b1, 1'b0);
        apb(1'b1, PR, 32'h3);
        apb(1'b1, PR, 32'h2);
        apb(1'b0, PR, 32'h0);
        check(rd, 32'h2, "area a released");
        cmd_try(1'b0, 1'b1);
    endtask
    task automatic t_flags();
        eng.ready <= 1'b0;
        pulse(0);
        apb(1'b0, ST, 32'h0);
        check(rd, 32'h40, "busy with rom access");
        eng.ready <= 1'b1;
        apb(1'b0, ST, 32'h0);
        check(rd, 32'hc3, "ready again");
        apb(1'b1, CT, 32'h3);
        check({31'h0, flash_irq}, 32'h1, "ready irq");
        apb(1'b1, CT, 32'h5);
        check({31'h0, flash_irq}, 32'h1, "busy read irq");
        apb(1'b1, ST, 32'hc2);
        apb(1'b1, ST, 32'h02);
        apb(1'b0, ST, 32'h0);
        check(rd, 32'hc3, "unarmed clear held");
        apb(1'b1, ST, 32'h82);
        apb(1'b0, ST, 32'h0);
        check(rd, 32'h83, "busy read cleared");
        check({31'h0, flash_irq}, 32'h0, "irq dropped");
        apb(1'b1, ST, 32'h02);
        apb(1'b1, ST, 32'hc2);
        apb(1'b0, ST, 32'h0);
        check(rd, 32'h03, "ready flag cleared, ones ignored");
    endtask
    task automatic t_errors();
        pulse(2);
        apb(1'b0, ST, 32'h0);
        check(rd, 32'h23, "erase error");
        eng.suspend <= 1'b1;
        pulse(3);
        apb(1'b0, ST, 32'h0);
        check(rd, 32'h3b, "program error and suspend");
        eng.suspend <= 1'b0;
        pulse(1);
        apb(1'b0, ST, 32'h0);
        check(rd, 32'h03, "clear status");
        apb(1'b1, 32'h03fc1994, 32'hff);
        check({31'h0, err}, 32'h1, "unmapped write error");
        apb(1'b0, 32'h03fc1994, 32'h0);
        check({err, rd[30:0]}, 32'h80000000, "unmapped read");
    endtask
    // =========================================
    // main sequence and hang guard
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_protect();
        t_flags();
        t_errors();
        conclude();
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            $display("mismatch at %0t: run timed out", $time);
            conclude();
        end
    end
endmodule
